//--- asm_pkg.sv
// Shared constants and carriers for the alarm and status monitor
package asm_pkg;
  // All percent quantities use 0.01 % per count, full scale = 10000
  localparam logic [15:0] PCT_FLOW_SET = 16'h2AF8;
  localparam logic [15:0] PCT_FLOW_CLR = 16'h2904;
  localparam logic [15:0] PCT_SP_SET = 16'h2904;
  localparam logic [15:0] PCT_SP_CLR = 16'h27D8;
  localparam logic [15:0] PCT_NO_FLOW = 16'h00C8;
  localparam logic [15:0] PCT_AOUT_TOL = 16'h03E8;
  localparam logic [16:0] CTRL_CLAMP = 17'h0C350;
  localparam logic [15:0] DAC_MIN = 16'h0000;
  localparam logic [15:0] DAC_MAX = 16'h2710;
  localparam logic [12:0] AMB_MARGIN_C = 13'h0005;
  localparam logic [15:0] SUPPLY_MIN_MV = 16'h2EE0;
  localparam logic [7:0] PARAM_COUNT = 8'h40;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CHECK_PERIOD_S = 1;
  localparam int unsigned SEC_CYCLES = CLK_HZ * CHECK_PERIOD_S;
  localparam int unsigned BLINK_PROM_HZ = 20;
  localparam int unsigned BLINK_SRAM_HZ = 10;
  localparam int unsigned BLINK_DB_HZ = 5;
  localparam int unsigned BLINK_WARN_HZ = 2;
  localparam int unsigned HALF_PROM = CLK_HZ / (2 * BLINK_PROM_HZ);
  localparam int unsigned HALF_SRAM = CLK_HZ / (2 * BLINK_SRAM_HZ);
  localparam int unsigned HALF_DB = CLK_HZ / (2 * BLINK_DB_HZ);
  localparam int unsigned HALF_WARN = CLK_HZ / (2 * BLINK_WARN_HZ);

  typedef enum logic [7:0] {
    ST_OK, ST_PROM_FAIL, ST_SRAM_FAIL, ST_DB_CORRUPT, ST_NV_CORRUPT, ST_ZERO_FAIL,
    ST_FLOW_SENS, ST_TEMP_SENS, ST_AOUT_ERR, ST_FLOW_OVR, ST_AOUT_OVR, ST_SP_OVR,
    ST_VALVE_OVR, ST_NO_FLOW, ST_AMB_HIGH, ST_AMB_LOW, ST_POWER_LOW
  } asm_status_e;

  typedef struct packed {
    logic [15:0] flow;
    logic [15:0] flow_offset;
    logic [15:0] temp_sens;
    logic [15:0] temp_offset;
    logic [15:0] aout_meas;
    logic [15:0] aout_expect;
    logic [15:0] aout_req;
    logic [15:0] setpoint;
    logic sp_analog_sel;
    logic [16:0] pid_req;
    logic signed [11:0] amb_temp;
    logic signed [11:0] amb_max;
    logic signed [11:0] amb_min;
    logic [15:0] supply_mv;
  } asm_meas_s;

  typedef struct packed {
    logic flow_sens;
    logic temp_sens;
    logic aout_err;
    logic flow_ovr;
    logic aout_ovr;
    logic sp_ovr;
    logic valve_ovr;
    logic no_flow;
    logic amb_high;
    logic amb_low;
    logic power_low;
  } asm_warn_s;

  typedef struct packed {
    logic prom;
    logic sram;
    logic db;
    logic nv;
    logic zero;
  } asm_fatal_s;
endpackage : asm_pkg

//--- asm_blink.sv
// LED blink generator with a programmable half-period divider
`timescale 1ns/10ps
`default_nettype none
module asm_blink (
  input wire logic i_sys_clk,
  input wire logic i_rst_n,
  input wire logic i_enable,
  input wire logic [31:0] i_half_period,
  output logic o_led
);
  logic [31:0] cnt_reg;
  logic [31:0] cnt_next;
  logic led_reg;
  logic led_next;

  // A rate change applies to the half-period already being counted, so a shorter one can toggle the LED early
  always_comb
  begin
    cnt_next = cnt_reg;
    led_next = led_reg;
    if (!i_enable)
    begin
      cnt_next = 32'h0;
      led_next = 1'b0;
    end
    else if (cnt_reg + 32'h1 >= i_half_period)
    begin
      cnt_next = 32'h0;
      led_next = !led_reg;
    end
    else
    begin
      cnt_next = cnt_reg + 32'h1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_reg <= 32'h0;
      led_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      led_reg <= led_next;
    end
  end

  assign o_led = led_reg;
endmodule : asm_blink
`default_nettype wire

//--- asm_monitor.sv
// Alarm and status monitor: limit checks, fatal latches, LED, alarm pin, status code
// Summary of operation
// - Any limit exceeded: warning, 2 Hz, alarm, status
// - Sensor below residual offset flags sensor error
// - Output deviating over 10% flags output error
// - Flow overrange above 110%, clears below 105%
// - Output request outside converter range flags overrange
// - Analog setpoint above 105% alarms, clears below 102%
// - Clamp control at five times full scale
// - Valve overrange with flow below 2% flags no-flow
// - Ambient 5 C beyond ratings alarms, clears within
// - Supply below 12 V raises power alarm
// - Program checksum failure: 20 Hz, alarm, no communication
// - Working memory failure: 10 Hz, alarm, no communication
// - Parameter checksum failure: 5 Hz, alarm, stop control
// - Backup compare failure: 5 Hz, alarm, stop control
// - Sensor zero failure: 5 Hz, alarm, stop control
// - Check one parameter per second, working then backup
`timescale 1ns/10ps
`default_nettype none
module asm_monitor #(
  parameter int unsigned SEC_CYCLES = asm_pkg::SEC_CYCLES,
  parameter int unsigned HALF_PROM = asm_pkg::HALF_PROM,
  parameter int unsigned HALF_SRAM = asm_pkg::HALF_SRAM,
  parameter int unsigned HALF_DB = asm_pkg::HALF_DB,
  parameter int unsigned HALF_WARN = asm_pkg::HALF_WARN
) (
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire asm_pkg::asm_meas_s i_meas,
  input wire logic i_prom_fail,
  input wire logic i_sram_fail,
  input wire logic i_zero_fail,
  input wire logic i_chk_done,
  input wire logic i_chk_bad,
  output logic o_chk_req,
  output logic o_chk_backup,
  output logic [7:0] o_chk_index,
  output logic [15:0] o_ctrl_out,
  output logic o_flow_ctrl_en,
  output logic o_comm_en,
  output logic o_alarm_out,
  output logic o_alarm_oe_n,
  output logic o_led,
  output asm_pkg::asm_status_e o_status_code,
  output logic o_status_strobe,
  output asm_pkg::asm_warn_s o_warn,
  output asm_pkg::asm_fatal_s o_fatal
);
  logic rst_meta_reg, rst_n;
  default clocking cb_sys @(posedge i_sys_clk);
  endclocking
  default disable iff (!rst_n);
  always_ff @(posedge i_sys_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
      {rst_n, rst_meta_reg} <= 2'b00;
    else
      {rst_n, rst_meta_reg} <= {rst_meta_reg, 1'b1};
  end
  asm_pkg::asm_warn_s warn_reg, warn_next;
  asm_pkg::asm_fatal_s fatal_reg, fatal_next;
  logic [15:0] ctrl_reg, ctrl_next;
  logic [15:0] aout_diff;
  logic signed [12:0] amb_t;
  logic any_fatal, any_warn, stop_ctrl;
  assign aout_diff = (i_meas.aout_meas > i_meas.aout_expect) ?
    (i_meas.aout_meas - i_meas.aout_expect) : (i_meas.aout_expect - i_meas.aout_meas);
  assign amb_t = 13'(i_meas.amb_temp);
  assign stop_ctrl = |fatal_reg;
  // Warnings are recomputed every cycle, only the hysteresis ones hold state
  always_comb
  begin
    warn_next.flow_sens = i_meas.flow < i_meas.flow_offset;
    warn_next.temp_sens = i_meas.temp_sens < i_meas.temp_offset;
    warn_next.aout_err = aout_diff > asm_pkg::PCT_AOUT_TOL;
    warn_next.flow_ovr = warn_reg.flow_ovr ? (i_meas.flow >= asm_pkg::PCT_FLOW_CLR) :
      (i_meas.flow > asm_pkg::PCT_FLOW_SET);
    warn_next.aout_ovr = (i_meas.aout_req < asm_pkg::DAC_MIN) ||
      (i_meas.aout_req > asm_pkg::DAC_MAX);
    warn_next.sp_ovr = i_meas.sp_analog_sel &&
      (warn_reg.sp_ovr ? (i_meas.setpoint >= asm_pkg::PCT_SP_CLR) :
      (i_meas.setpoint > asm_pkg::PCT_SP_SET));
    warn_next.valve_ovr = i_meas.pid_req >= asm_pkg::CTRL_CLAMP;
    warn_next.no_flow = warn_next.valve_ovr &&
      (i_meas.flow < asm_pkg::PCT_NO_FLOW);
    warn_next.amb_high = warn_reg.amb_high ? (amb_t > 13'(i_meas.amb_max)) :
      (amb_t > 13'(i_meas.amb_max) + $signed(asm_pkg::AMB_MARGIN_C));
    warn_next.amb_low = warn_reg.amb_low ? (amb_t < 13'(i_meas.amb_min)) :
      (amb_t < 13'(i_meas.amb_min) - $signed(asm_pkg::AMB_MARGIN_C));
    warn_next.power_low = i_meas.supply_mv < asm_pkg::SUPPLY_MIN_MV;
    // Latches only ever set; reset is the sole way out
    fatal_next.prom = fatal_reg.prom | i_prom_fail;
    fatal_next.sram = fatal_reg.sram | i_sram_fail;
    fatal_next.db = fatal_reg.db | (i_chk_done & i_chk_bad & !o_chk_backup);
    fatal_next.nv = fatal_reg.nv | (i_chk_done & i_chk_bad & o_chk_backup);
    fatal_next.zero = fatal_reg.zero | i_zero_fail;
    if (stop_ctrl)
      ctrl_next = 16'h0000;
    else if (i_meas.pid_req >= asm_pkg::CTRL_CLAMP)
      ctrl_next = asm_pkg::CTRL_CLAMP[15:0];
    else
      ctrl_next = i_meas.pid_req[15:0];
  end
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      warn_reg <= '0;
      fatal_reg <= '0;
      ctrl_reg <= 16'h0000;
    end
    else
    begin
      warn_reg <= warn_next;
      fatal_reg <= fatal_next;
      ctrl_reg <= ctrl_next;
    end
  end
  assign any_fatal = |fatal_reg;
  assign any_warn = |warn_reg;
  // Parameter scan: one request per second, working copy then backup
  logic [31:0] sec_reg, sec_next;
  logic req_reg, req_next;
  logic bank_reg, bank_next;
  logic [7:0] idx_reg, idx_next;
  always_comb
  begin
    sec_next = sec_reg + 32'h1;
    req_next = 1'b0;
    bank_next = bank_reg;
    idx_next = idx_reg;
    if (sec_reg + 32'h1 >= SEC_CYCLES)
    begin
      sec_next = 32'h0;
      req_next = !stop_ctrl;
    end
    // Index and bank move after the answer, so the result pairs with them
    if (i_chk_done)
    begin
      if (idx_reg == asm_pkg::PARAM_COUNT - 8'h01)
      begin
        idx_next = 8'h00;
        bank_next = !bank_reg;
      end
      else
        idx_next = idx_reg + 8'h01;
    end
  end
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sec_reg <= 32'h0;
      req_reg <= 1'b0;
      bank_reg <= 1'b0;
      idx_reg <= 8'h00;
    end
    else
    begin
      sec_reg <= sec_next;
      req_reg <= req_next;
      bank_reg <= bank_next;
      idx_reg <= idx_next;
    end
  end
  // Rate selection; program memory failure outranks working memory failure
  logic [31:0] half_sel;
  always_comb
  begin
    if (fatal_reg.prom)
      half_sel = HALF_PROM;
    else if (fatal_reg.sram)
      half_sel = HALF_SRAM;
    else if (fatal_reg.db | fatal_reg.nv | fatal_reg.zero)
      half_sel = HALF_DB;
    else
      half_sel = HALF_WARN;
  end
  asm_blink u_blink (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(rst_n),
    .i_enable(any_fatal | any_warn),
    .i_half_period(half_sel),
    .o_led(o_led)
  );
  // Status code: fatal first, then the first warning in list order, but no-flow ahead of valve overrange
  asm_pkg::asm_status_e code_reg, code_next;
  logic strobe_reg, strobe_next;
  always_comb
  begin
    code_next = asm_pkg::ST_OK;
    if (fatal_reg.prom) code_next = asm_pkg::ST_PROM_FAIL;
    else if (fatal_reg.sram) code_next = asm_pkg::ST_SRAM_FAIL;
    else if (fatal_reg.db) code_next = asm_pkg::ST_DB_CORRUPT;
    else if (fatal_reg.nv) code_next = asm_pkg::ST_NV_CORRUPT;
    else if (fatal_reg.zero) code_next = asm_pkg::ST_ZERO_FAIL;
    else if (warn_reg.flow_sens) code_next = asm_pkg::ST_FLOW_SENS;
    else if (warn_reg.temp_sens) code_next = asm_pkg::ST_TEMP_SENS;
    else if (warn_reg.aout_err) code_next = asm_pkg::ST_AOUT_ERR;
    else if (warn_reg.flow_ovr) code_next = asm_pkg::ST_FLOW_OVR;
    else if (warn_reg.aout_ovr) code_next = asm_pkg::ST_AOUT_OVR;
    else if (warn_reg.sp_ovr) code_next = asm_pkg::ST_SP_OVR;
    else if (warn_reg.no_flow) code_next = asm_pkg::ST_NO_FLOW;
    else if (warn_reg.valve_ovr) code_next = asm_pkg::ST_VALVE_OVR;
    else if (warn_reg.amb_high) code_next = asm_pkg::ST_AMB_HIGH;
    else if (warn_reg.amb_low) code_next = asm_pkg::ST_AMB_LOW;
    else if (warn_reg.power_low) code_next = asm_pkg::ST_POWER_LOW;
    // Host is told only while the link may talk
    strobe_next = (code_next != code_reg) && !(fatal_reg.prom | fatal_reg.sram);
  end
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      code_reg <= asm_pkg::ST_OK;
      strobe_reg <= 1'b0;
    end
    else
    begin
      code_reg <= code_next;
      strobe_reg <= strobe_next;
    end
  end
  assign o_chk_req = req_reg;
  assign o_chk_backup = bank_reg;
  assign o_chk_index = idx_reg;
  assign o_ctrl_out = ctrl_reg;
  assign o_flow_ctrl_en = !stop_ctrl;
  assign o_comm_en = !(fatal_reg.prom | fatal_reg.sram);
  // Open collector: only ever pulls low, enable low while pulling
  assign o_alarm_out = 1'b0;
  assign o_alarm_oe_n = !(any_fatal | any_warn);
  assign o_status_code = code_reg;
  assign o_status_strobe = strobe_reg;
  assign o_warn = warn_reg;
  assign o_fatal = fatal_reg;
  property p_prom_effect;
    fatal_reg.prom |-> (!o_alarm_oe_n && !o_comm_en && half_sel == HALF_PROM);
  endproperty
  a_prom_effect: assert property (p_prom_effect) else $error("prom fault effect");
  property p_sram_effect;
    $rose(fatal_reg.sram) && !fatal_reg.prom |-> !o_comm_en && half_sel == HALF_SRAM;
  endproperty
  a_sram_effect: assert property (p_sram_effect) else $error("sram fault effect");
  property p_db_stop;
    i_chk_done && i_chk_bad && !o_chk_backup |=> !o_flow_ctrl_en ##1 o_ctrl_out == 16'h0000;
  endproperty
  a_db_stop: assert property (p_db_stop) else $error("db fault no stop");
  property p_latch;
    $rose(fatal_reg.zero) |=> fatal_reg.zero [*8];
  endproperty
  a_latch: assert property (p_latch) else $error("fatal flag dropped");
  property p_flow_hyst;
    warn_reg.flow_ovr && i_meas.flow >= asm_pkg::PCT_FLOW_CLR |=> warn_reg.flow_ovr;
  endproperty
  a_flow_hyst: assert property (p_flow_hyst) else $error("flow overrange cleared early");
  property p_clamp;
    i_meas.pid_req > asm_pkg::CTRL_CLAMP && !stop_ctrl |=>
      o_ctrl_out == asm_pkg::CTRL_CLAMP[15:0] && warn_reg.valve_ovr;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp missing");
  property p_no_flow;
    warn_reg.no_flow |-> warn_reg.valve_ovr && $past(i_meas.flow) < asm_pkg::PCT_NO_FLOW;
  endproperty
  a_no_flow: assert property (p_no_flow) else $error("no-flow without cause");
  // Pin and flag checked together: the supply may recover one cycle later
  property p_power;
    i_meas.supply_mv < asm_pkg::SUPPLY_MIN_MV |=> warn_reg.power_low && !o_alarm_oe_n;
  endproperty
  a_power: assert property (p_power) else $error("power alarm missing");
  property p_warn_rate;
    any_warn && !any_fatal |-> half_sel == HALF_WARN && !o_alarm_oe_n;
  endproperty
  a_warn_rate: assert property (p_warn_rate) else $error("warning rate wrong");
  property p_chk_space;
    o_chk_req |=> !o_chk_req [*8];
  endproperty
  a_chk_space: assert property (p_chk_space) else $error("checks too close");
  c_warn: cover property (@(posedge i_sys_clk) disable iff (!rst_n) $rose(warn_reg.flow_ovr));
  c_db: cover property (@(posedge i_sys_clk) disable iff (!rst_n) $rose(fatal_reg.db));
  c_bank: cover property (@(posedge i_sys_clk) disable iff (!rst_n) $rose(o_chk_backup));
  c_led: cover property (@(posedge i_sys_clk) disable iff (!rst_n) $rose(o_led));
endmodule : asm_monitor
`default_nettype wire

//--- asm_chk_model.sv
// Behavioural parameter checker that answers the monitor's check requests
`timescale 1ns/10ps
`default_nettype none
module asm_chk_model (
  input wire logic i_sys_clk,
  input wire logic i_chk_req,
  input wire logic i_chk_backup,
  input wire logic [7:0] i_chk_index,
  input wire logic i_bad_en,
  input wire logic i_bad_bank,
  input wire logic [7:0] i_bad_index,
  input wire logic [3:0] i_delay,
  output logic o_chk_done,
  output logic o_chk_bad
);
  logic hit;
  // Answers on the falling edge; between answers the verdict line is not trustworthy
  initial
  begin
    o_chk_done = 1'b0;
    o_chk_bad = 1'b1;
    hit = 1'b0;
    forever
    begin
      @(negedge i_sys_clk);
      if (i_chk_req === 1'b1)
      begin
        hit = i_bad_en && (i_chk_backup == i_bad_bank) && (i_chk_index == i_bad_index);
        repeat (i_delay) @(negedge i_sys_clk);
        o_chk_done = 1'b1;
        o_chk_bad = hit;
        @(negedge i_sys_clk);
        o_chk_done = 1'b0;
        o_chk_bad = ~hit;
      end
    end
  end
endmodule : asm_chk_model
`default_nettype wire

//--- asm_monitor_tb.sv
// Self-checking bench for the alarm and status monitor
`timescale 1ns/10ps
`default_nettype none
module asm_monitor_tb;
  localparam int unsigned SEC = 20;
  logic clk, rst_n, prom_f, sram_f, zero_f, done, bad, req, bank;
  logic fce, comm, aout, oe_n, led, strobe, bad_en, bad_bank;
  logic [7:0] idx;
  logic [7:0] bad_idx;
  logic [3:0] delay;
  logic [15:0] ctrl;
  asm_pkg::asm_meas_s meas;
  asm_pkg::asm_meas_s nom;
  asm_pkg::asm_status_e code;
  asm_pkg::asm_warn_s warn;
  asm_pkg::asm_fatal_s fatal;
  int fail_count, n_compared;

  // Short divider values keep blink and scan checks within a few thousand cycles
  asm_monitor #(.SEC_CYCLES(SEC), .HALF_PROM(2), .HALF_SRAM(3), .HALF_DB(4), .HALF_WARN(5)) DUT (
    .i_sys_clk(clk), .i_reset_n(rst_n), .i_meas(meas), .i_prom_fail(prom_f),
    .i_sram_fail(sram_f), .i_zero_fail(zero_f), .i_chk_done(done), .i_chk_bad(bad),
    .o_chk_req(req), .o_chk_backup(bank), .o_chk_index(idx), .o_ctrl_out(ctrl),
    .o_flow_ctrl_en(fce), .o_comm_en(comm), .o_alarm_out(aout), .o_alarm_oe_n(oe_n),
    .o_led(led), .o_status_code(code), .o_status_strobe(strobe), .o_warn(warn),
    .o_fatal(fatal));

  asm_chk_model PART (.i_sys_clk(clk), .i_chk_req(req), .i_chk_backup(bank),
    .i_chk_index(idx), .i_bad_en(bad_en), .i_bad_bank(bad_bank), .i_bad_index(bad_idx),
    .i_delay(delay), .o_chk_done(done), .o_chk_bad(bad));

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : cmp_val

  task automatic cmp_code(input asm_pkg::asm_status_e got, input asm_pkg::asm_status_e exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: code %0h expected %0h", $time, got, exp);
    end
  endtask : cmp_code

  task automatic conclude;
    if (fail_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : conclude

  task automatic settle;
    repeat (4) @(negedge clk);
  endtask : settle

  task automatic do_reset;
    @(negedge clk);
    rst_n = 1'b0;
    meas = nom;
    {prom_f, sram_f, zero_f, bad_en} = 4'h0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
  endtask : do_reset

  task automatic led_half(output int n);
    logic l;
    int k;
    l = led;
    k = 0;
    while (led === l && k < 200)
    begin
      @(negedge clk);
      k++;
    end
    l = led;
    n = 0;
    while (led === l && n < 200)
    begin
      @(negedge clk);
      n++;
    end
  endtask : led_half

  task automatic strobe_within(input int k, output logic seen);
    seen = 1'b0;
    repeat (k)
    begin
      @(negedge clk);
      if (strobe === 1'b1)
        seen = 1'b1;
    end
  endtask : strobe_within

  task automatic warn_case(input asm_pkg::asm_meas_s m, input logic [10:0] exp);
    meas = m;
    settle;
    cmp_val(warn, exp);
  endtask : warn_case

  task automatic t_flow;
    int n;
    logic s;
    do_reset;
    warn_case(nom, 11'h000);
    cmp_code(code, asm_pkg::ST_OK);
    meas.flow = 16'h2AF8;
    settle;
    cmp_val(warn, 11'h000);
    meas.flow = 16'h2AF9;
    strobe_within(8, s);
    cmp_val(s, 1'b1);
    cmp_val({warn.flow_ovr, oe_n, fce, aout}, 4'hA);
    cmp_code(code, asm_pkg::ST_FLOW_OVR);
    led_half(n);
    cmp_val(n, 5);
    meas.flow = 16'h2904;
    settle;
    cmp_val(warn.flow_ovr, 1'b1);
    meas.flow = 16'h2903;
    settle;
    cmp_val({warn.flow_ovr, oe_n}, 2'h1);
  endtask : t_flow

  task automatic t_limits;
    asm_pkg::asm_meas_s m;
    m = nom;
    m.setpoint = 16'h2905;
    warn_case(m, 11'h000);
    m.sp_analog_sel = 1'b1;
    warn_case(m, 11'h020);
    m.setpoint = 16'h27D8;
    warn_case(m, 11'h020);
    m.setpoint = 16'h27D7;
    warn_case(m, 11'h000);
    m = nom;
    m.pid_req = 17'h0C351;
    warn_case(m, 11'h010);
    cmp_val(ctrl, 16'hC350);
    m.flow = 16'h00C7;
    warn_case(m, 11'h018);
    m.flow = 16'h00C8;
    warn_case(m, 11'h010);
    m = nom;
    m.pid_req = 17'h0C34F;
    warn_case(m, 11'h000);
    cmp_val(ctrl, 16'hC34F);
    m = nom;
    m.flow = 16'h0063;
    warn_case(m, 11'h400);
    m = nom;
    m.temp_sens = 16'h0063;
    warn_case(m, 11'h200);
    m = nom;
    m.aout_meas = 16'h1770;
    warn_case(m, 11'h000);
    m.aout_meas = 16'h1771;
    warn_case(m, 11'h100);
    m = nom;
    m.aout_req = 16'h2710;
    warn_case(m, 11'h000);
    m.aout_req = 16'h2711;
    warn_case(m, 11'h040);
    m = nom;
    m.amb_temp = 12'sh04C;
    warn_case(m, 11'h004);
    m.amb_temp = 12'sh047;
    warn_case(m, 11'h004);
    m.amb_temp = 12'sh046;
    warn_case(m, 11'h000);
    m.amb_temp = -12'sh006;
    warn_case(m, 11'h002);
    m.amb_temp = 12'sh000;
    warn_case(m, 11'h000);
    m = nom;
    m.supply_mv = 16'h2EDF;
    warn_case(m, 11'h001);
    m.supply_mv = 16'h2EE0;
    warn_case(m, 11'h000);
  endtask : t_limits

  // Fatal raised by a one-cycle pulse while a warning is active as well
  task automatic t_fatal(input logic [2:0] src, input int half, input logic [4:0] exp_f,
      input asm_pkg::asm_status_e exp_c, input logic talk);
    int n;
    logic s;
    do_reset;
    meas.flow = 16'h2AF9;
    settle;
    {prom_f, sram_f, zero_f} = src;
    @(negedge clk);
    {prom_f, sram_f, zero_f} = 3'h0;
    strobe_within(8, s);
    cmp_val(s, talk);
    cmp_val({fatal, comm, fce, oe_n}, {exp_f, talk, 2'h0});
    cmp_val(ctrl, 16'h0000);
    cmp_code(code, exp_c);
    led_half(n);
    cmp_val(n, half);
  endtask : t_fatal

  task automatic t_scan(input logic b_bank, input logic [7:0] b_idx, input logic [3:0] dly,
      input int exp_reqs, input logic [4:0] exp_f, input asm_pkg::asm_status_e exp_c);
    int k, reqs, t1, t2, n;
    do_reset;
    bad_bank = b_bank;
    bad_idx = b_idx;
    bad_en = 1'b1;
    delay = dly;
    reqs = 0;
    k = 0;
    t1 = 0;
    t2 = 0;
    while (fatal === 5'h00 && k < 70 * SEC)
    begin
      @(negedge clk);
      k++;
      if (req === 1'b1)
      begin
        reqs++;
        t1 = t2;
        t2 = k;
      end
    end
    cmp_val(t2 - t1, SEC);
    cmp_val(reqs, exp_reqs);
    settle;
    cmp_val({fatal, fce, oe_n}, {exp_f, 2'h0});
    cmp_code(code, exp_c);
    led_half(n);
    cmp_val(n, 4);
  endtask : t_scan

  initial
  begin
    fail_count = 0;
    n_compared = 0;
    rst_n = 1'b0;
    {prom_f, sram_f, zero_f, bad_en, bad_bank} = 5'h00;
    bad_idx = 8'h00;
    delay = 4'h2;
    nom = '0;
    nom.flow = 16'h1388;
    nom.flow_offset = 16'h0064;
    nom.temp_sens = 16'h1388;
    nom.temp_offset = 16'h0064;
    nom.aout_meas = 16'h1388;
    nom.aout_expect = 16'h1388;
    nom.aout_req = 16'h1388;
    nom.setpoint = 16'h1388;
    nom.pid_req = 17'h02710;
    nom.amb_temp = 12'sh019;
    nom.amb_max = 12'sh046;
    nom.supply_mv = 16'h3A98;
    meas = nom;
    t_flow;
    t_limits;
    t_fatal(3'h4, 2, 5'h10, asm_pkg::ST_PROM_FAIL, 1'b0);
    t_fatal(3'h2, 3, 5'h08, asm_pkg::ST_SRAM_FAIL, 1'b0);
    t_fatal(3'h1, 4, 5'h01, asm_pkg::ST_ZERO_FAIL, 1'b1);
    t_scan(1'b0, 8'h03, 4'h1, 4, 5'h04, asm_pkg::ST_DB_CORRUPT);
    t_scan(1'b1, 8'h00, 4'hF, 65, 5'h02, asm_pkg::ST_NV_CORRUPT);
    conclude;
  end

  // Whole run needs about 1700 cycles
  initial
  begin
    repeat (20000) @(negedge clk);
    fail_count++;
    conclude;
  end
endmodule : asm_monitor_tb
`default_nettype wire
